// >>> rtl/sac_pkg.sv
// Notes on behaviour
// - Falling convert_start_n edge holds sample, starts conversion; in low-power it starts wake and acquisition first.
// - Sixteen-step binary search, most significant first.
// - Form output code, then drop busy.
// - Result belongs to this conversion's own sample.
// - Exactly three modes: high-rate, normal, low-power.
// - High-rate converts fastest; accuracy needs starts at most 1 ms apart.
// - Normal mode has no interval limit.
// - Low-power mode idles analog between conversions.
// - coding_select picks binary or two's complement only while CTRL_CODE_BIT is set.
// - Binary code counts whole steps above zero.
// - Two's complement is binary with top bit inverted.
// - Underrange saturates to the minimum code.
// - Low-power: start held low converts after acquisition.
// - High reset input aborts any conversion.
// - Power-down finishes current conversion, then inhibits.
package sac_pkg;
   localparam int unsigned CLK_MHZ        = 125;
   localparam int unsigned NBITS          = 16;
   localparam int unsigned BIT_NS_FAST    = 50;
   localparam int unsigned BIT_NS_NORMAL  = 70;
   localparam int unsigned ACQ_NS_FAST    = 150;
   localparam int unsigned ACQ_NS_NORMAL  = 250;
   localparam int unsigned ACQ_NS_LOWPWR  = 1000;
   localparam int unsigned WAKE_NS_LOWPWR = 400;
   localparam int unsigned GAP_US_FAST    = 1000;
   localparam int unsigned BIT_CYC_FAST   = (BIT_NS_FAST * CLK_MHZ) / 1000;
   localparam int unsigned BIT_CYC_NORMAL = (BIT_NS_NORMAL * CLK_MHZ) / 1000;
   localparam int unsigned ACQ_CYC_FAST   = (ACQ_NS_FAST * CLK_MHZ + 999) / 1000;
   localparam int unsigned ACQ_CYC_NORMAL = (ACQ_NS_NORMAL * CLK_MHZ + 999) / 1000;
   localparam int unsigned ACQ_CYC_LOWPWR = (ACQ_NS_LOWPWR * CLK_MHZ + 999) / 1000;
   localparam int unsigned WAKE_CYC       = (WAKE_NS_LOWPWR * CLK_MHZ + 999) / 1000;
   localparam int unsigned GAP_CYC_FAST   = GAP_US_FAST * CLK_MHZ;
   localparam int unsigned CNT_W          = 18;

   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_STATUS = 8'h04;
   localparam logic [7:0]  ADDR_RESULT = 8'h08;
   localparam logic [7:0]  ADDR_COUNT  = 8'h0C;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0005;
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_CODE_BIT = 2;
   localparam int unsigned CTRL_PD_BIT   = 3;
   localparam int unsigned CTRL_RST_BIT  = 4;

   localparam logic [15:0] MID_CODE  = 16'h8000;
   localparam logic [15:0] FULL_CODE = 16'hFFFF;
   localparam logic [15:0] ZERO_CODE = 16'h0000;

   typedef enum logic [1:0] {
      SAC_MODE_FAST,
      SAC_MODE_NORMAL,
      SAC_MODE_LOWPWR
   } sac_mode_t;

   typedef enum logic [2:0] {
      SAC_ST_IDLE,
      SAC_ST_WAKE,
      SAC_ST_ACQ,
      SAC_ST_CONV,
      SAC_ST_DONE
   } sac_state_t;

   typedef struct packed {
      logic [15:0] code;
      logic        stale;
      logic        sat;
   } sac_result_t;

   function automatic logic [15:0] sac_format(input logic [15:0] bin, input logic straight);
      sac_format = straight ? bin : {~bin[15], bin[14:0]};
   endfunction
endpackage

// >>> rtl/sac_skid.sv
`timescale 1ns/1ps
module sac_skid (
   // Clock and reset.
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 ce,
   // Input side.
   input  wire logic                 in_valid,
   output logic                      in_ready,
   input  wire sac_pkg::sac_result_t in_data,
   // Output side.
   output logic                      out_valid,
   input  wire logic                 out_ready,
   output sac_pkg::sac_result_t      out_data
);
   typedef struct packed {
      sac_pkg::sac_result_t [1:0] mem;
      logic                       rd;
      logic                       wr;
      logic [1:0]                 cnt;
   } sac_skid_st_t;

   sac_skid_st_t s_q;
   sac_skid_st_t s_d;
   logic         push;
   logic         pop;

   assign in_ready  = (s_q.cnt != 2'h2);
   assign out_valid = (s_q.cnt != 2'h0);
   assign out_data  = s_q.mem[s_q.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wr] = in_data;
         s_d.wr          = ~s_q.wr;
      end
      if (pop)
      begin
         s_d.rd = ~s_q.rd;
      end
      s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
      end
      else if (ce)
      begin
         s_q <= s_d;
      end
   end

   chk_skid_no_over: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.cnt <= 2'h2) else $error("buffer count exceeds two");
endmodule

// >>> rtl/sac_cycle_timer.sv
`timescale 1ns/1ps
module sac_cycle_timer (
   // Clock and reset.
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          ce,
   // Control.
   input  wire logic                          load,
   input  wire logic [sac_pkg::CNT_W-1:0]     value,
   // Status.
   output logic                               expired
);
   typedef struct packed {
      logic [sac_pkg::CNT_W-1:0] cnt;
   } sac_tmr_st_t;

   sac_tmr_st_t s_q;
   sac_tmr_st_t s_d;

   assign expired = (s_q.cnt == '0);

   always_comb
   begin
      s_d = s_q;
      if (load)
      begin
         s_d.cnt = value;
      end
      else if (!expired)
      begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
      end
      else if (ce)
      begin
         s_q <= s_d;
      end
   end
endmodule

// >>> rtl/sac_ctrl.sv
`timescale 1ns/1ps
module sac_ctrl (
   // APB slave.
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  ce,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Conversion pins.
   input  wire logic                  convert_start_n,
   input  wire logic                  reset_in,
   input  wire logic                  power_down_in,
   input  wire logic                  coding_select,
   output logic                       busy,
   // Analog front end controls and comparator.
   output logic                       track,
   output logic                       analog_on,
   output logic [15:0]                dac_bits,
   input  wire logic                  comp_high,
   input  wire logic                  over_range,
   input  wire logic                  under_range,
   // Result stream.
   output logic                       res_valid,
   input  wire logic                  res_ready,
   output sac_pkg::sac_result_t       res_data
);
   typedef struct packed {
      sac_pkg::sac_state_t  st;
      logic                 start_n_prev;
      logic [15:0]          trial;
      logic [15:0]          bit_mask;
      logic [15:0]          code;
      logic                 stale;
      logic                 sat;
      logic                 emit;
      logic [1:0]           mode;
      logic                 ctrl_code;
      logic                 ctrl_pd;
      logic [31:0]          rdata;
      logic [15:0]          conv_count;
      logic                 gap_long;
   } sac_ctrl_st_t;

   sac_ctrl_st_t         s_q;
   sac_ctrl_st_t         s_d;
   logic                 wr_en;
   logic                 rd_en;
   logic                 start_fall;
   logic                 pd_req;
   logic                 straight;
   logic                 acq_done;
   logic                 gap_done;
   logic                 tmr_load;
   logic [sac_pkg::CNT_W-1:0] tmr_val;
   logic                 buf_ready;
   logic                 gap_load;
   sac_pkg::sac_result_t push_data;

   // The slave never stalls, so every access completes in its first access cycle.
   assign pready     = 1'b1;
   assign wr_en      = psel && penable && pwrite;
   assign rd_en      = psel && !penable && !pwrite;
   assign pslverr    = psel && penable && (paddr > sac_pkg::ADDR_COUNT);
   assign prdata     = s_q.rdata;
   assign start_fall = s_q.start_n_prev && !convert_start_n;
   assign pd_req     = power_down_in || s_q.ctrl_pd;
   assign straight   = coding_select && s_q.ctrl_code;
   assign busy       = (s_q.st == sac_pkg::SAC_ST_CONV) || (s_q.st == sac_pkg::SAC_ST_DONE);
   assign track      = (s_q.st == sac_pkg::SAC_ST_IDLE) || (s_q.st == sac_pkg::SAC_ST_ACQ);
   // Analog bias is dropped while idle in low-power mode or while idle and powered down.
   assign analog_on  = !(pd_req && s_q.st == sac_pkg::SAC_ST_IDLE)
                    && !(s_q.mode == 2'(sac_pkg::SAC_MODE_LOWPWR)
                         && s_q.st == sac_pkg::SAC_ST_IDLE);
   assign dac_bits   = s_q.trial | s_q.bit_mask;
   assign push_data  = '{code: s_q.code, stale: s_q.stale, sat: s_q.sat};
   assign gap_load   = start_fall && s_q.st == sac_pkg::SAC_ST_IDLE;

   // The timer acts one cycle after it reaches zero, so a load of n minus one spaces steps n apart.
   function automatic logic [sac_pkg::CNT_W-1:0] bit_cycles(input logic [1:0] m);
      bit_cycles = (m == 2'(sac_pkg::SAC_MODE_FAST)) ? sac_pkg::CNT_W'(sac_pkg::BIT_CYC_FAST - 1)
                                                     : sac_pkg::CNT_W'(sac_pkg::BIT_CYC_NORMAL - 1);
   endfunction

   sac_cycle_timer u_step (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .load    (tmr_load),
      .value   (tmr_val),
      .expired (acq_done)
   );

   // Measures the 1 ms spacing that high-rate accuracy relies on.
   sac_cycle_timer u_gap (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .load    (gap_load),
      .value   (sac_pkg::CNT_W'(sac_pkg::GAP_CYC_FAST - 1)),
      .expired (gap_done)
   );

   sac_skid u_buf (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (ce),
      .in_valid  (s_q.emit),
      .in_ready  (buf_ready),
      .in_data   (push_data),
      .out_valid (res_valid),
      .out_ready (res_ready),
      .out_data  (res_data)
   );

   always_comb
   begin
      s_d              = s_q;
      tmr_load         = 1'b0;
      tmr_val          = '0;
      s_d.start_n_prev = convert_start_n;
      if (s_q.emit && buf_ready)
      begin
         s_d.emit = 1'b0;
      end
      if (wr_en && paddr == sac_pkg::ADDR_CTRL)
      begin
         if (pwdata[1:0] != 2'h3)
         begin
            s_d.mode = pwdata[1:0];
         end
         s_d.ctrl_code = pwdata[sac_pkg::CTRL_CODE_BIT];
         s_d.ctrl_pd   = pwdata[sac_pkg::CTRL_PD_BIT];
      end
      case (paddr)
         sac_pkg::ADDR_CTRL:   s_d.rdata = {28'h0, s_q.ctrl_pd, s_q.ctrl_code, s_q.mode};
         sac_pkg::ADDR_STATUS: s_d.rdata = {27'h0, s_q.gap_long, s_q.emit, res_valid,
                                            analog_on, busy};
         sac_pkg::ADDR_RESULT: s_d.rdata = {14'h0, res_data.sat, res_data.stale, res_data.code};
         sac_pkg::ADDR_COUNT:  s_d.rdata = {16'h0, s_q.conv_count};
         default:              s_d.rdata = 32'h0000_0000;
      endcase
      if (!rd_en)
      begin
         s_d.rdata = s_q.rdata;
      end
      case (s_q.st)
         sac_pkg::SAC_ST_IDLE:
         begin
            if (gap_done)
            begin
               s_d.gap_long = 1'b1;
            end
            if (start_fall && !pd_req && !s_q.emit)
            begin
               s_d.stale    = (s_q.mode == 2'(sac_pkg::SAC_MODE_FAST))
                           && (s_q.gap_long || gap_done);
               s_d.gap_long = 1'b0;
               if (s_q.mode == 2'(sac_pkg::SAC_MODE_LOWPWR))
               begin
                  s_d.st   = sac_pkg::SAC_ST_WAKE;
                  tmr_load = 1'b1;
                  tmr_val  = sac_pkg::CNT_W'(sac_pkg::WAKE_CYC - 1);
               end
               else
               begin
                  s_d.st       = sac_pkg::SAC_ST_CONV;
                  s_d.trial    = '0;
                  s_d.bit_mask = sac_pkg::MID_CODE;
                  tmr_load     = 1'b1;
                  tmr_val      = bit_cycles(s_q.mode);
               end
            end
         end
         sac_pkg::SAC_ST_WAKE:
         begin
            // Bias settles, then acquisition runs before the hold.
            if (acq_done)
            begin
               s_d.st   = sac_pkg::SAC_ST_ACQ;
               tmr_load = 1'b1;
               tmr_val  = sac_pkg::CNT_W'(sac_pkg::ACQ_CYC_LOWPWR - 1);
            end
         end
         sac_pkg::SAC_ST_ACQ:
         begin
            if (acq_done && !convert_start_n)
            begin
               s_d.st       = sac_pkg::SAC_ST_CONV;
               s_d.trial    = '0;
               s_d.bit_mask = sac_pkg::MID_CODE;
               tmr_load     = 1'b1;
               tmr_val      = bit_cycles(s_q.mode);
            end
         end
         sac_pkg::SAC_ST_CONV:
         begin
            if (acq_done)
            begin
               if (comp_high)
               begin
                  s_d.trial = s_q.trial | s_q.bit_mask;
               end
               s_d.bit_mask = s_q.bit_mask >> 1;
               tmr_load     = 1'b1;
               tmr_val      = bit_cycles(s_q.mode);
               if (s_q.bit_mask[0])
               begin
                  s_d.st = sac_pkg::SAC_ST_DONE;
               end
            end
         end
         sac_pkg::SAC_ST_DONE:
         begin
            s_d.sat = over_range || under_range;
            if (over_range)
            begin
               s_d.code = sac_pkg::sac_format(sac_pkg::FULL_CODE, straight);
            end
            else if (under_range)
            begin
               s_d.code = sac_pkg::sac_format(sac_pkg::ZERO_CODE, straight);
            end
            else
            begin
               s_d.code = sac_pkg::sac_format(s_q.trial, straight);
            end
            s_d.emit       = 1'b1;
            s_d.conv_count = s_q.conv_count + 16'h0001;
            s_d.st         = sac_pkg::SAC_ST_IDLE;
         end
         default:
         begin
            s_d.st = sac_pkg::SAC_ST_IDLE;
         end
      endcase
      if (reset_in || (wr_en && paddr == sac_pkg::ADDR_CTRL && pwdata[sac_pkg::CTRL_RST_BIT]))
      begin
         s_d.st       = sac_pkg::SAC_ST_IDLE;
         s_d.bit_mask = '0;
         s_d.emit     = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q              <= '0;
         s_q.start_n_prev <= 1'b1;
         s_q.mode         <= sac_pkg::CTRL_RESET[1:0];
         s_q.ctrl_code    <= sac_pkg::CTRL_RESET[sac_pkg::CTRL_CODE_BIT];
         s_q.gap_long     <= 1'b1;
      end
      else if (ce)
      begin
         s_q <= s_d;
      end
   end

   chk_busy_after_start: assert property (@(posedge pclk) disable iff (!presetn || reset_in)
      ce && start_fall && s_q.st == sac_pkg::SAC_ST_IDLE && !pd_req && !s_q.emit
      && s_q.mode != 2'(sac_pkg::SAC_MODE_LOWPWR) |=> busy)
      else $error("conversion did not start");
   chk_msb_first: assert property (@(posedge pclk) disable iff (!presetn)
      ce && $rose(busy) && !reset_in |-> s_q.bit_mask == sac_pkg::MID_CODE)
      else $error("search did not start at top bit");
   chk_code_before_idle: assert property (@(posedge pclk) disable iff (!presetn)
      ce && s_q.st == sac_pkg::SAC_ST_DONE && !reset_in |=> !busy && s_q.emit)
      else $error("busy fell without result");
   chk_twos_mid: assert property (@(posedge pclk) disable iff (!presetn)
      ce && s_q.st == sac_pkg::SAC_ST_DONE && !over_range && !under_range && !straight
      && !reset_in |=> s_q.code == (s_q.trial ^ 16'h8000))
      else $error("midscale two's complement wrong");
   chk_over_sat: assert property (@(posedge pclk) disable iff (!presetn)
      ce && s_q.st == sac_pkg::SAC_ST_DONE && over_range && straight && !reset_in
      |=> s_q.code == 16'hFFFF)
      else $error("overrange not saturated");
   chk_under_sat: assert property (@(posedge pclk) disable iff (!presetn)
      ce && s_q.st == sac_pkg::SAC_ST_DONE && under_range && !over_range && !straight
      && !reset_in |=> s_q.code == 16'h8000)
      else $error("underrange not saturated");
   chk_reset_abort: assert property (@(posedge pclk) disable iff (!presetn)
      ce && reset_in |=> !busy)
      else $error("reset did not abort");
   chk_pd_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
      ce && pd_req && s_q.st == sac_pkg::SAC_ST_IDLE |=> !busy)
      else $error("conversion started in power down");
   chk_mode_legal: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.mode != 2'h3)
      else $error("illegal mode");
   chk_lowpwr_off: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.mode == 2'(sac_pkg::SAC_MODE_LOWPWR) && s_q.st == sac_pkg::SAC_ST_IDLE
      |-> !analog_on)
      else $error("bias on while idle in low power");
   cov_fast_conv: cover property (@(posedge pclk)
      s_q.mode == 2'(sac_pkg::SAC_MODE_FAST) && $fell(busy));
   cov_lowpwr_conv: cover property (@(posedge pclk)
      s_q.st == sac_pkg::SAC_ST_ACQ ##1 s_q.st == sac_pkg::SAC_ST_CONV);
   cov_sat: cover property (@(posedge pclk) s_q.st == sac_pkg::SAC_ST_DONE && over_range);
   cov_abort: cover property (@(posedge pclk) busy && reset_in);
endmodule

// >>> tb/sac_afe_model.sv
`timescale 1ns/1ps
module sac_afe_model (
   // Clock.
   input  wire logic        pclk,
   // Sampling switch and trial pattern.
   input  wire logic        track,
   input  wire logic [15:0] dac_bits,
   // Analog input stand-in.
   input  wire logic [15:0] vin,
   input  wire logic        ovr,
   input  wire logic        und,
   // Comparator side.
   output logic             comp_high,
   output logic             over_range,
   output logic             under_range
);
   logic [15:0] held_q;

   // The array follows the input while tracking and keeps it once the switch opens.
   always_ff @(posedge pclk)
   begin
      if (track)
      begin
         held_q      <= vin;
         over_range  <= ovr;
         under_range <= und;
      end
   end

   // An underrange sample keeps no bit, even when also overrange; any other overrange sample keeps every bit.
   assign comp_high = !under_range && (over_range || held_q >= dac_bits);
endmodule

// >>> tb/sac_conversion_control_bench.sv
`timescale 1ns/1ps
module sac_conversion_control_bench;
   typedef struct packed {
      logic [1:0]  mode;
      logic        cs;
      logic [15:0] v;
      logic        ov;
      logic        un;
      logic        st;
   } sac_row_t;

   logic                 pclk = 1'b0;
   logic                 ce = 1'b1;
   logic                 presetn = 1'b0;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [7:0]           paddr = 8'h00;
   logic [31:0]          pwdata = 32'h0000_0000;
   logic                 convert_start_n = 1'b1;
   logic                 reset_in = 1'b0;
   logic                 power_down_in = 1'b0;
   logic                 coding_select = 1'b1;
   logic                 res_ready = 1'b0;
   logic [15:0]          vin = 16'h0000;
   logic                 ovr = 1'b0;
   logic                 und = 1'b0;
   logic [31:0]          prdata;
   logic [31:0]          rd;
   logic                 pready;
   logic                 pslverr;
   logic                 busy;
   logic                 track;
   logic                 analog_on;
   logic [15:0]          dac_bits;
   logic                 comp_high;
   logic                 over_range;
   logic                 under_range;
   logic                 res_valid;
   logic                 e;
   logic                 g;
   sac_pkg::sac_result_t res_data;
   int                   err_count = 0;
   int                   checked = 0;
   int                   cyc = 0;
   int                   cnt;
   sac_row_t             rows [9] = '{
      '{2'h0, 1'b1, 16'h1234, 1'b0, 1'b0, 1'b1},
      '{2'h0, 1'b0, 16'h8000, 1'b0, 1'b0, 1'b0},
      '{2'h1, 1'b1, 16'h8000, 1'b0, 1'b0, 1'b0},
      '{2'h1, 1'b0, 16'h7FFF, 1'b0, 1'b0, 1'b0},
      '{2'h2, 1'b0, 16'h0001, 1'b0, 1'b0, 1'b0},
      '{2'h1, 1'b1, 16'h5555, 1'b1, 1'b0, 1'b0},
      '{2'h1, 1'b0, 16'h5555, 1'b1, 1'b0, 1'b0},
      '{2'h1, 1'b1, 16'h5555, 1'b0, 1'b1, 1'b0},
      '{2'h1, 1'b0, 16'h5555, 1'b0, 1'b1, 1'b0}};

   always #4 pclk = ~pclk;

   sac_ctrl u_sac_ctrl (
      .pclk            (pclk),
      .presetn         (presetn),
      .ce              (ce),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .convert_start_n (convert_start_n),
      .reset_in        (reset_in),
      .power_down_in   (power_down_in),
      .coding_select   (coding_select),
      .busy            (busy),
      .track           (track),
      .analog_on       (analog_on),
      .dac_bits        (dac_bits),
      .comp_high       (comp_high),
      .over_range      (over_range),
      .under_range     (under_range),
      .res_valid       (res_valid),
      .res_ready       (res_ready),
      .res_data        (res_data)
   );

   sac_afe_model u_sac_afe_model (
      .pclk        (pclk),
      .track       (track),
      .dac_bits    (dac_bits),
      .vin         (vin),
      .ovr         (ovr),
      .und         (und),
      .comp_high   (comp_high),
      .over_range  (over_range),
      .under_range (under_range)
   );

   function automatic logic [15:0] expect_code(input sac_row_t r);
      logic [15:0] b;
      b = r.ov ? 16'hFFFF : (r.un ? 16'h0000 : r.v);
      expect_code = r.cs ? b : {~b[15], b[14:0]};
   endfunction

   task automatic end_of_test();
      if (err_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Holds the start low until busy shows, so a low-power acquisition still converts.
   task automatic start(output logic got, output int c, input logic ab, input logic pd);
      int n;
      @(posedge pclk);
      convert_start_n <= 1'b0;
      n = 0;
      while (busy !== 1'b1 && n < 400)
      begin
         @(posedge pclk);
         n++;
      end
      got = busy;
      convert_start_n <= 1'b1;
      c = 0;
      if (got === 1'b1)
      begin
         chk("first trial", dac_bits, 16'h8000);
         vin <= ~vin;
         power_down_in <= pd;
         if (ab)
         begin
            repeat (20) @(posedge pclk);
            reset_in <= 1'b1;
            @(posedge pclk);
            reset_in <= 1'b0;
         end
         while (busy !== 1'b0 && c < 400)
         begin
            @(posedge pclk);
            c++;
         end
      end
   endtask

   task automatic pop(input logic [15:0] c, input logic st, input logic sat);
      int n;
      n = 0;
      while (res_valid !== 1'b1 && n < 10)
      begin
         @(posedge pclk);
         n++;
      end
      chk("result code", res_data.code, c);
      chk("stale flag", res_data.stale, st);
      chk("saturated", res_data.sat, sat);
      apb(1'b0, sac_pkg::ADDR_RESULT, 32'h0000_0000, rd, e);
      chk("result reg", rd[15:0], c);
      res_ready <= 1'b1;
      @(posedge pclk);
      res_ready <= 1'b0;
      @(posedge pclk);
   endtask

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_count++;
         end_of_test();
      end
   end

   initial
   begin
      repeat (8) @(posedge pclk);
      chk("reset busy", busy, 1'b0);
      chk("reset track", track, 1'b1);
      chk("reset bias", analog_on, 1'b1);
      chk("reset trial", dac_bits, 16'h0000);
      chk("reset result", res_valid, 1'b0);
      presetn <= 1'b1;
      apb(1'b0, sac_pkg::ADDR_CTRL, 32'h0000_0000, rd, e);
      chk("ctrl reset", rd, sac_pkg::CTRL_RESET);
      apb(1'b1, sac_pkg::ADDR_CTRL, 32'h0000_0007, rd, e);
      apb(1'b0, sac_pkg::ADDR_CTRL, 32'h0000_0000, rd, e);
      chk("mode field", rd[1:0], 2'h1);
      apb(1'b0, 8'h10, 32'h0000_0000, rd, e);
      chk("unmapped err", e, 1'b1);
      chk("unmapped data", rd, 32'h0000_0000);
      for (int i = 0; i < 9; i++)
      begin
         apb(1'b1, sac_pkg::ADDR_CTRL, {28'h0000000, 2'b01, rows[i].mode}, rd, e);
         coding_select <= rows[i].cs;
         vin <= rows[i].v;
         ovr <= rows[i].ov;
         und <= rows[i].un;
         start(g, cnt, 1'b0, 1'b0);
         chk("started", g, 1'b1);
         if (rows[i].mode != 2'h2)
            chk("busy cycles", cnt, (rows[i].mode == 2'h0) ? 97 : 129);
         pop(expect_code(rows[i]), rows[i].st, rows[i].ov | rows[i].un);
      end
      apb(1'b0, sac_pkg::ADDR_COUNT, 32'h0000_0000, rd, e);
      chk("conversions", rd, 32'h0000_0009);
      apb(1'b1, sac_pkg::ADDR_CTRL, 32'h0000_0006, rd, e);
      apb(1'b0, sac_pkg::ADDR_STATUS, 32'h0000_0000, rd, e);
      chk("status idle", rd, 32'h0000_0000);
      chk("lowpwr bias", analog_on, 1'b0);
      apb(1'b1, sac_pkg::ADDR_CTRL, 32'h0000_0005, rd, e);
      coding_select <= 1'b1;
      ovr <= 1'b0;
      und <= 1'b0;
      // Abort in mid-search: busy drops and no result appears.
      start(g, cnt, 1'b1, 1'b0);
      chk("abort quick", cnt < 4, 1'b1);
      repeat (20) @(posedge pclk);
      chk("abort no data", res_valid, 1'b0);
      // Power-down while converting: the result lands, the next start is ignored.
      vin <= 16'h4321;
      start(g, cnt, 1'b0, 1'b1);
      pop(16'h4321, 1'b0, 1'b0);
      start(g, cnt, 1'b0, 1'b0);
      chk("pd refuse", g, 1'b0);
      chk("pd bias", analog_on, 1'b0);
      power_down_in <= 1'b0;
      // Two unread results fill the buffer; a third waits unpushed and blocks a fourth start.
      vin <= 16'h0F0F;
      start(g, cnt, 1'b0, 1'b0);
      vin <= 16'hF0F0;
      start(g, cnt, 1'b0, 1'b0);
      start(g, cnt, 1'b0, 1'b0);
      chk("pending start", g, 1'b1);
      start(g, cnt, 1'b0, 1'b0);
      chk("full refuse", g, 1'b0);
      pop(16'h0F0F, 1'b0, 1'b0);
      pop(16'hF0F0, 1'b0, 1'b0);
      pop(16'h0F0F, 1'b0, 1'b0);
      // A low clock enable freezes the idle state, so a start pulse in that time is lost.
      ce <= 1'b0;
      convert_start_n <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("frozen busy", busy, 1'b0);
      convert_start_n <= 1'b1;
      @(posedge pclk);
      ce <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("frozen after", busy, 1'b0);
      end_of_test();
   end
endmodule
